// ---- hdl/sbc_pkg.sv ----
package sbc_pkg;

    // Array geometry
    localparam int ADDR_W  = 20;
    localparam int LANE_W  = 9;
    localparam int LANES   = 2;
    localparam int DATA_W  = LANE_W * LANES;
    localparam int BURST_W = 2;

    // Cycles of ignored inputs after snooze release
    localparam logic [1:0] WAKE_CYCLES = 2'h2;

    // Values after reset
    localparam logic [1:0]                BURST_RST  = 2'h0;
    localparam logic [1:0]                WAKE_RST   = 2'h0;
    localparam logic [ADDR_W-BURST_W-1:0] ADDR_HI_RST = '0;

    // Operation held by the burst engine
    typedef enum logic [1:0] {
        OP_DESEL,
        OP_READ,
        OP_WRITE
    } sbc_op_e;

    // Synchronous control pins, sampled together on the rising edge
    typedef struct packed {
        logic             chip_select_low_first;
        logic             chip_select_high;
        logic             chip_select_low_second;
        logic             advance_or_load;
        logic             read_not_write;
        logic [LANES-1:0] lane_write_enable_n;
        logic             out_enable_n;
        logic             clock_gate_n;
    } sbc_cmd_s;

endpackage

// ---- hdl/sbc_array.sv ----
`timescale 1ns/10ps
module sbc_array
    import sbc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int LW = LANE_W,
    parameter int NL = LANES
)
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // Access port
    input  wire logic               re_i,
    input  wire logic [NL-1:0]      we_i,
    input  wire logic [AW-1:0]      addr_i,
    input  wire logic [NL*LW-1:0]   wdata_i,
    output logic      [NL*LW-1:0]   rdata_o
);

    // One storage column per byte lane, each with its own write strobe
    for (genvar g = 0; g < NL; g++)
    begin : g_lane
        logic [LW-1:0] mem [0:(2**AW)-1];

        // Lane write, no reset on the array itself
        always_ff @(posedge clk_i)
        begin
            if (we_i[g])
            begin
                mem[addr_i] <= wdata_i[g*LW +: LW];
            end
        end

        // Registered read data; holds when no read is done
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                rdata_o[g*LW +: LW] <= '0;
            end
            else if (re_i)
            begin
                rdata_o[g*LW +: LW] <= mem[addr_i];
            end
        end
    end

endmodule // sbc_array

// ---- hdl/sbc_top.sv ----
// Functional notes
// - Continuation cycles keep the operation type chosen at burst start.
// - Advance while deselected keeps the data pins high-impedance.
// - Dummy reads and write aborts do nothing externally but still step bursts.
// - Write with all lane enables high is accepted but writes nothing.
// - Output drivers are off during writes regardless of output enable.
// - Clock gated during a read keeps the data bus driven.
// - Clock gated during a write keeps bus off and writes nothing.
// - Each lane write enable gates only its own nine-bit lane.
// - Synchronous inputs are sampled on the rising clock edge.
// - Data pins stay high-impedance from power-up until a read.
// - Two-bit burst counter wraps to the start every fourth continuation cycle.
// - Burst counter advances on every continuation cycle, aborts included.
// - Write is active with any lane enable low, abort when all high.
// - Selected load with read starts read burst; drives only if output enabled.
// - Selected load with write and lane enabled starts write burst, captures data.
// - Advance during read bursts outputs next address, ignoring selects and direction.
// - Advance during write bursts writes enabled lanes at the next address.
// - Order select high gives interleaved order, low gives linear wrapping order.
// - Advance ignores external address, selects and direction; counter steps instead.
`timescale 1ns/10ps
module sbc_top
    import sbc_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK_I,
    input  wire logic              NRST_I,
    // Command and address
    input  wire sbc_cmd_s          CMD_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    // Static and power control
    input  wire logic              LINEAR_ORDER_SELECT_N_I,
    input  wire logic              SNOOZE_REQUEST_I,
    // Data pins, split into in, out and enable
    input  wire logic [DATA_W-1:0] DATA_PINS_I,
    output logic      [DATA_W-1:0] DATA_PINS_O,
    output logic                   DATA_PINS_OE_O,
    // Status
    output sbc_op_e                CUR_OP_O,
    output logic [BURST_W-1:0]     BURST_COUNT_O
);

    // Burst engine state
    sbc_op_e                     state_ff;
    sbc_op_e                     nxt_state;
    logic [BURST_W-1:0]          start_ff;
    logic [BURST_W-1:0]          nxt_start;
    logic [BURST_W-1:0]          cnt_ff;
    logic [BURST_W-1:0]          nxt_cnt;
    logic [ADDR_W-BURST_W-1:0]   addr_hi_ff;
    logic [ADDR_W-BURST_W-1:0]   nxt_addr_hi;
    logic                        dq_oe_ff;
    logic                        nxt_dq_oe;
    logic [1:0]                  wake_ff;
    logic [1:0]                  nxt_wake;

    // Array access of this cycle
    logic [ADDR_W-1:0]           mem_addr;
    logic [LANES-1:0]            mem_we;
    logic                        mem_re;

    // Decoded command terms
    logic                        sel_all;
    logic                        act;
    logic                        load;
    logic                        adv;
    logic                        cont_ok;
    logic [BURST_W-1:0]          cnt_inc;
    logic [BURST_W-1:0]          seq_next;

    // Burst order: xor with start when interleaved, wrapping add when linear
    function automatic logic [BURST_W-1:0] burst_seq(input logic [BURST_W-1:0] start,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic               interleave);
        logic [BURST_W-1:0] res;
        res = interleave ? (start ^ cnt) : BURST_W'(start + cnt);
        return res;
    endfunction

    // Command decode terms
    // Wake-up window and wait states both block every command
    // sampled on edge
    assign sel_all  = !CMD_I.chip_select_low_first && CMD_I.chip_select_high
                      && !CMD_I.chip_select_low_second;
    assign act      = !SNOOZE_REQUEST_I && (wake_ff == WAKE_RST) && !CMD_I.clock_gate_n;
    assign load     = act && !CMD_I.advance_or_load;
    assign adv      = act && CMD_I.advance_or_load;
    assign cont_ok  = adv && (state_ff != OP_DESEL);
    assign cnt_inc  = BURST_W'(cnt_ff + 2'h1);
    assign seq_next = burst_seq(start_ff, cnt_inc, LINEAR_ORDER_SELECT_N_I);

    // Next state of the burst engine and array strobes
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_start   = start_ff;
        nxt_cnt     = cnt_ff;
        nxt_addr_hi = addr_hi_ff;
        nxt_dq_oe   = dq_oe_ff;
        nxt_wake    = wake_ff;
        mem_addr    = {addr_hi_ff, seq_next};
        mem_we      = '0;
        mem_re      = 1'b0;
        // Snooze outranks all, then wake-up, then wait states
        if (SNOOZE_REQUEST_I)
        begin
            // Snooze drops any burst; inputs stay ignored for a while after
            nxt_state = OP_DESEL;
            nxt_dq_oe = 1'b0;
            nxt_wake  = WAKE_CYCLES;
        end
        else if (wake_ff != WAKE_RST)
        begin
            nxt_wake = wake_ff - 2'h1;
        end
        else if (CMD_I.clock_gate_n)
        begin
            nxt_state = state_ff;
        end
        else if (!CMD_I.advance_or_load)
        begin
            if (!sel_all)
            begin
                nxt_state = OP_DESEL;
                nxt_dq_oe = 1'b0;
            end
            else
            begin
                nxt_addr_hi = ADDR_I[ADDR_W-1:BURST_W];
                nxt_start   = ADDR_I[BURST_W-1:0];
                nxt_cnt     = BURST_RST;
                mem_addr    = ADDR_I;
                if (CMD_I.read_not_write)
                begin
                    nxt_state = OP_READ;
                    nxt_dq_oe = !CMD_I.out_enable_n;
                    mem_re    = !CMD_I.out_enable_n;
                end
                else
                begin
                    nxt_state = OP_WRITE;
                    nxt_dq_oe = 1'b0;
                    mem_we    = ~CMD_I.lane_write_enable_n;
                end
            end
        end
        else
        begin
            case (state_ff)
                OP_READ:
                begin
                    nxt_cnt   = cnt_inc;
                    nxt_dq_oe = !CMD_I.out_enable_n;
                    mem_re    = !CMD_I.out_enable_n;
                end
                OP_WRITE:
                begin
                    nxt_cnt   = cnt_inc;
                    nxt_dq_oe = 1'b0;
                    mem_we    = ~CMD_I.lane_write_enable_n;
                end
                OP_DESEL:
                begin
                    nxt_dq_oe = 1'b0;
                end
                default:
                begin
                    // Unused code falls back to idle
                    nxt_state = OP_DESEL;
                    nxt_dq_oe = 1'b0;
                end
            endcase
        end
    end

    // Engine registers
    // power-up off
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            state_ff   <= OP_DESEL;
            start_ff   <= BURST_RST;
            cnt_ff     <= BURST_RST;
            addr_hi_ff <= ADDR_HI_RST;
            dq_oe_ff   <= 1'b0;
            wake_ff    <= WAKE_RST;
        end
        else
        begin
            state_ff   <= nxt_state;
            start_ff   <= nxt_start;
            cnt_ff     <= nxt_cnt;
            addr_hi_ff <= nxt_addr_hi;
            dq_oe_ff   <= nxt_dq_oe;
            wake_ff    <= nxt_wake;
        end
    end

    // Storage; read data register feeds the pins directly
    // Write data is taken on the command edge, no late-write stage
    // per-lane strobes
    sbc_array #(
        .AW (ADDR_W),
        .LW (LANE_W),
        .NL (LANES)
    ) u_array (
        .clk_i   (CLK_I),
        .rst_n_i (NRST_I),
        .re_i    (mem_re),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (DATA_PINS_I),
        .rdata_o (DATA_PINS_O)
    );

    // Status straight from the engine flops
    // Trade-off: output enable is sampled so every output stays registered
    assign DATA_PINS_OE_O = dq_oe_ff;
    assign CUR_OP_O       = state_ff;
    assign BURST_COUNT_O  = cnt_ff;

    // Checks on the engine
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    AST_SAME_TYPE: assert property (cont_ok |=> CUR_OP_O == $past(CUR_OP_O))
        else $error("Continuation changed operation type");
    AST_CONT_DESEL: assert property (adv && state_ff == OP_DESEL |=> !DATA_PINS_OE_O && CUR_OP_O == OP_DESEL)
        else $error("Continue deselect drove the pins");
    AST_ABORT: assert property (cont_ok && state_ff == OP_WRITE && (&CMD_I.lane_write_enable_n)
                                |-> mem_we == '0)
        else $error("Write abort wrote the array");
    AST_WRITE_OFF: assert property (CUR_OP_O == OP_WRITE |-> !DATA_PINS_OE_O)
        else $error("Drivers on during write");
    AST_GATED_HOLD: assert property (!SNOOZE_REQUEST_I && wake_ff == WAKE_RST && CMD_I.clock_gate_n
                                     |=> $stable(DATA_PINS_OE_O) && $stable(CUR_OP_O) && $stable(DATA_PINS_O))
        else $error("Gated cycle changed outputs");
    AST_GATED_NOWRITE: assert property (CMD_I.clock_gate_n |-> mem_we == '0)
        else $error("Array written in gated cycle");
    AST_LANE_MAP: assert property (cont_ok && state_ff == OP_WRITE |-> mem_we == ~CMD_I.lane_write_enable_n)
        else $error("Lane strobe mismatch");
    AST_WRAP: assert property (cont_ok ##1 cont_ok ##1 cont_ok ##1 cont_ok
                               |=> BURST_COUNT_O == $past(BURST_COUNT_O, 4))
        else $error("Burst counter did not wrap after four");
    AST_COUNT_STEP: assert property (cont_ok |=> BURST_COUNT_O == BURST_W'($past(BURST_COUNT_O) + 2'h1))
        else $error("Burst counter did not step");
    AST_READ_START: assert property (load && sel_all && CMD_I.read_not_write
                                     |=> DATA_PINS_OE_O == !$past(CMD_I.out_enable_n)
                                         && BURST_COUNT_O == BURST_RST)
        else $error("Read start drive wrong");
    AST_DESEL: assert property (load && !sel_all |=> !DATA_PINS_OE_O && CUR_OP_O == OP_DESEL)
        else $error("Deselect left drivers on");
    AST_ORDER: assert property (load && sel_all ##1 cont_ok && LINEAR_ORDER_SELECT_N_I
                                |-> mem_addr[1:0] == ($past(ADDR_I[1:0]) ^ 2'h1))
        else $error("Interleaved order wrong");
    AST_SNOOZE_OFF: assert property (SNOOZE_REQUEST_I |=> !DATA_PINS_OE_O ##1 !DATA_PINS_OE_O)
        else $error("Pins driven in or after snooze");

    // Array strobes and drive on the less common paths
    AST_READ_DRIVE: assert property (cont_ok && state_ff == OP_READ
                                     |=> DATA_PINS_OE_O == !$past(CMD_I.out_enable_n))
        else $error("Read continuation drive wrong");
    AST_DUMMY_HOLD: assert property (cont_ok && state_ff == OP_READ && CMD_I.out_enable_n
                                     |=> !DATA_PINS_OE_O && $stable(DATA_PINS_O))
        else $error("Dummy read touched the pins");
    AST_WRITE_START: assert property (load && sel_all && !CMD_I.read_not_write
                                      |-> mem_we == ~CMD_I.lane_write_enable_n && mem_addr == ADDR_I)
        else $error("Write start strobes wrong");
    AST_DESEL_IDLE: assert property (load && !sel_all |-> mem_we == '0 && !mem_re)
        else $error("Deselect touched the array");
    AST_ADDR_HELD: assert property (adv |-> mem_addr[ADDR_W-1:BURST_W] == addr_hi_ff)
        else $error("Advance used the external address");

    // Main scenarios
    COV_READ_BURST: cover property (load && sel_all && CMD_I.read_not_write ##1 cont_ok [*3]);
    COV_WRITE_BURST: cover property (load && sel_all && !CMD_I.read_not_write ##1 cont_ok [*3]);
    COV_GATED_READ: cover property (DATA_PINS_OE_O && CMD_I.clock_gate_n);
    COV_DUMMY_START: cover property (load && sel_all && CMD_I.read_not_write && CMD_I.out_enable_n);
    COV_SNOOZE: cover property (SNOOZE_REQUEST_I ##1 !SNOOZE_REQUEST_I ##3 load);

endmodule // sbc_top

// ---- verif/sbc_ctrl_model.sv ----
`timescale 1ns/10ps
module sbc_ctrl_model
    import sbc_pkg::*;
(
    // Clock
    input  wire logic          clk_i,
    // Synchronous command side
    output sbc_cmd_s           cmd_o,
    output logic [ADDR_W-1:0]  addr_o,
    output logic [DATA_W-1:0]  data_o,
    output logic               snooze_o
);
    // Idle: clock gated, lanes off, until the first command
    initial
    begin
        cmd_o = '1;
        addr_o = '0;
        data_o = '0;
        snooze_o = 1'b0;
    end

    // One command per cycle, launched just after the edge
    task automatic drive(input sbc_cmd_s c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic snz);
        @(posedge clk_i);
        #2;
        // held stable over the sampling edge
        cmd_o = c;
        addr_o = a;
        snooze_o = snz;
        // Lines carry no stale value when not writing
        data_o = (&c.lane_write_enable_n) ? ~data_o : d;
    endtask
endmodule // sbc_ctrl_model

// ---- verif/test_sync_sram_burst_command_decode.sv ----
`timescale 1ns/10ps
module test_sync_sram_burst_command_decode;
    import sbc_pkg::*;

    typedef struct {
        logic              oe;
        sbc_op_e           op;
        logic [1:0]        cnt;
        logic [DATA_W-1:0] dat;
        bit                full;
    } sbc_note_s;

    localparam logic [2:0] SEL = 3'b010;

    logic              clk, nrst, lbo_n, snooze, oe, e_oe;
    sbc_cmd_s          cmd;
    logic [ADDR_W-1:0] addr, base, e_base;
    logic [DATA_W-1:0] ctl_data, dout, e_dout;
    sbc_op_e           cur_op, e_op;
    logic [1:0]        cnt, e_cnt, wake;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [1:0]        lanes [6] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b00, 2'b00};
    logic [2:0]        dsel [3] = '{3'b110, 3'b000, 3'b011};
    sbc_note_s         q [$];
    int                miscompares, samples_checked, seed;

    // Free-running 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    sbc_ctrl_model u_sbc_ctrl_model (.clk_i(clk), .cmd_o(cmd), .addr_o(addr), .data_o(ctl_data), .snooze_o(snooze));

    // Pin level: device wins while its drivers are on
    sbc_top u_sbc_top (
        .CLK_I(clk), .NRST_I(nrst), .CMD_I(cmd), .ADDR_I(addr),
        .LINEAR_ORDER_SELECT_N_I(lbo_n), .SNOOZE_REQUEST_I(snooze),
        .DATA_PINS_I(oe ? dout : ctl_data), .DATA_PINS_O(dout), .DATA_PINS_OE_O(oe),
        .CUR_OP_O(cur_op), .BURST_COUNT_O(cnt));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Drive one cycle and note what the device must show after it
    task automatic cyc(input logic [2:0] cs, input logic adv, rnw, input logic [1:0] ln,
                       input logic oen, g, snz, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        sbc_cmd_s          c;
        logic [ADDR_W-1:0] na;
        c = '{cs[2], cs[1], cs[0], adv, rnw, ln, oen, g};
        u_sbc_ctrl_model.drive(c, a, d, snz);
        if (snz)
        begin
            e_op = OP_DESEL;
            e_oe = 1'b0;
            wake = WAKE_CYCLES;
        end
        else if (wake != 2'h0)
            wake = wake - 2'h1;
        else if (!g)
        begin
            if (!adv)
            begin
                e_base = a;
                e_cnt = 2'h0;
                e_op = (cs != SEL) ? OP_DESEL : rnw ? OP_READ : OP_WRITE;
            end
            else if (e_op != OP_DESEL)
                e_cnt = e_cnt + 2'h1;
            na = {e_base[ADDR_W-1:2], lbo_n ? e_base[1:0] ^ e_cnt : e_base[1:0] + e_cnt};
            e_oe = (e_op == OP_READ) && !oen;
            if (e_oe)
                e_dout = mem[na];
            if (e_op == OP_WRITE)
                for (int i = 0; i < LANES; i++)
                    if (!ln[i])
                        mem[na][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
        end
        q.push_back('{e_oe, e_op, e_cnt, e_dout, e_op != OP_DESEL});
    endtask

    // Scoreboard: each taken edge retires the oldest note
    initial
    begin
        sbc_note_s n;
        forever
        begin
            @(posedge clk);
            if (q.size() != 0)
            begin
                n = q.pop_front();
                @(negedge clk);
                chk("oe", 32'(oe), 32'(n.oe));
                chk("op", 32'(cur_op), 32'(n.op));
                if (n.full)
                begin
                    chk("count", 32'(cnt), 32'(n.cnt));
                    chk("data", 32'(dout), 32'(n.dat));
                end
            end
        end
    end

    // Hang guard, far beyond the fewer than a hundred cycles needed
    initial
    begin
        #100000;
        miscompares++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        seed = 32'hF38C1A62;
        nrst = 1'b0;
        lbo_n = 1'b0;
        wake = 2'h0;
        e_op = OP_DESEL;
        e_oe = 1'b0;
        e_cnt = 2'h0;
        e_dout = '0;
        e_base = '0;
        repeat (12) @(posedge clk);
        #2;
        chk("oe", 32'(oe), 32'h0);
        chk("data", 32'(dout), 32'h0);
        nrst = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            lbo_n = m[0];
            base = 20'($random(seed));
            cyc(3'b110, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
            // output enable tied low
            // Full fill, then per-lane, abort, gated and wrapping writes
            for (int p = 0; p < 2; p++)
                for (int k = 0; k < 6; k++)
                    cyc(k ? 3'($random(seed)) : SEL, k != 0, k != 0, p ? lanes[k] : 2'b00, 1'b0, k == 4, 1'b0,
                        k ? 20'($random(seed)) : base, 18'($random(seed)));
            cyc(3'b110, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
            // Read burst: four steps to the wrap, the second a dummy, then a wait state and one more step
            for (int k = 0; k < 7; k++)
                cyc(k ? 3'($random(seed)) : SEL, k != 0, k == 0, 2'b00, k == 2, k == 5, 1'b0,
                    k ? 20'($random(seed)) : base, 18'($random(seed)));
            // Deselect rows, one round opening with a dummy read
            foreach (dsel[i])
            begin
                cyc(SEL, 1'b0, 1'b1, 2'b11, i == 1, 1'b0, 1'b0, base, '0);
                cyc(dsel[i], 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
                cyc(dsel[i], 1'b1, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
            end
            // Aborted write load leaves the word intact
            cyc(SEL, 1'b0, 1'b0, 2'b11, 1'b0, 1'b0, 1'b0, base, 18'($random(seed)));
            cyc(SEL, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
            cyc(SEL, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b1, base, '0);
            cyc(3'b110, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
            cyc(3'b110, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
            cyc(SEL, 1'b0, 1'b1, 2'b11, 1'b0, 1'b0, 1'b0, base, '0);
        end
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule // test_sync_sram_burst_command_decode
